// File: verilog/spmsp_port.sv
`timescale 1ns/10ps
`include "spmsp_defs.svh"
module spmsp_port
   import spmsp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // control bits
   input  wire logic       port_enable_set,
   input  wire logic       master_select_set,
   input  wire logic       cfg_clk_polarity,
   input  wire logic       cfg_clk_phase,
   input  wire logic       low_bit_first,
   input  wire logic [1:0] rate_select,
   input  wire logic       select_pin_override,
   input  wire logic       select_output_enable,
   input  wire logic       port_irq_enable,
   input  wire logic       gpio_select_out,
   // data register access
   input  wire logic       data_wr,
   input  wire logic [7:0] data_wr_value,
   output logic      [7:0] serial_data_reg,
   // status flags and clears
   input  wire logic       done_clear,
   input  wire logic       overrun_clear,
   input  wire logic       collision_clear,
   input  wire logic       fault_clear,
   output logic            port_enable,
   output logic            master_select,
   output logic            transfer_done_flag,
   output logic            overrun_flag,
   output logic            write_collision_flag,
   output logic            fault_flag,
   output logic            port_irq,
   output logic            port_busy,
   // pins
   input  wire logic       shift_clock_line_in,
   output logic            shift_clock_line_out,
   output logic            shift_clock_line_oe,
   input  wire logic       select_n_in,
   output logic            select_n_out,
   output logic            select_n_oe,
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe,
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe
);
   typedef struct packed {
      spmsp_state_t state;
      logic         enable;
      logic         master;
      logic [7:0]   shifter;
      logic [2:0]   bit_cnt;
      logic         edge_odd;      // next edge is the first of a bit
      logic [7:0]   div_cnt;
      logic         sclk;          // master clock level, idle phase
      logic         out_bit;
      logic         done;
      logic         ovr;
      logic         col;
      logic         fault;
      logic         buf_full;      // read buffer holds an unread byte
      logic [2:0]   sck_sync;      // two sync stages plus edge history
      logic [1:0]   ss_sync;
      logic [1:0]   mosi_sync;
      logic [1:0]   miso_sync;
   } spmsp_st_t;

   spmsp_st_t  st_q;
   spmsp_st_t  st_d;
   logic       rx_load;
   logic [7:0] rx_byte;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] half_period(input logic [1:0] rs);
      unique case (rs)
         `SPMSP_RATE_DIV8:   half_period = `SPMSP_HALF_DIV8;
         `SPMSP_RATE_DIV32:  half_period = `SPMSP_HALF_DIV32;
         `SPMSP_RATE_DIV128: half_period = `SPMSP_HALF_DIV128;
         default:            half_period = `SPMSP_HALF_DIV256;
      endcase
   endfunction : half_period

   // bit leaving the shifter, by order
   function automatic logic head_bit(input logic [7:0] s, input logic lsb);
      head_bit = lsb ? s[0] : s[7];
   endfunction : head_bit

   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic lsb,
                                           input logic b);
      shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
   endfunction : shift_in

   // ************************************************************
   // next state
   // ************************************************************
   logic [1:0] role;
   logic       ss_low;
   logic       sck_edge;
   logic       sample_now;
   logic       in_bit;
   logic       is_master;
   // decoded role, synchronised select and clock edge
   assign role      = {select_pin_override, select_output_enable};
   assign ss_low    = ~st_q.ss_sync[1];
   assign is_master = st_q.enable & st_q.master;
   assign sck_edge  = st_q.sck_sync[2] ^ st_q.sck_sync[1];
   assign in_bit    = is_master ? st_q.miso_sync[1] : st_q.mosi_sync[1];

   always_comb begin
      st_d           = st_q;
      rx_load        = 1'b0;
      sample_now     = 1'b0;
      st_d.sck_sync  = {st_q.sck_sync[1:0], shift_clock_line_in};
      st_d.ss_sync   = {st_q.ss_sync[0], select_n_in};
      st_d.mosi_sync = {st_q.mosi_sync[0], mosi_in};
      st_d.miso_sync = {st_q.miso_sync[0], miso_in};
      // software enables; flag clears lose to a same-cycle set below
      st_d.enable = port_enable_set;
      st_d.master = master_select_set;
      if (done_clear) st_d.done = 1'b0;
      if (overrun_clear) st_d.ovr = 1'b0;
      if (collision_clear) st_d.col = 1'b0;
      if (fault_clear) st_d.fault = 1'b0;
      if (~st_q.buf_full | done_clear) st_d.buf_full = 1'b0;
      // data write: start as master when idle, else collision
      if (data_wr & st_q.enable) begin
         if (st_q.state != SPMSP_IDLE) begin
            st_d.col = 1'b1;
         end else begin
            st_d.shifter = data_wr_value;
            if (is_master) begin
               st_d.state    = SPMSP_SHIFT;
               st_d.bit_cnt  = 3'h0;
               st_d.edge_odd = 1'b1;
               st_d.div_cnt  = half_period(rate_select);
               st_d.out_bit  = head_bit(data_wr_value, low_bit_first);
            end
         end
      end
      // slave: a clock edge with select low arms a transfer; phase 0 leads with data
      if (st_q.enable & ~st_q.master) begin
         if (~ss_low) begin
            if (st_q.state == SPMSP_SHIFT) begin
               st_d.shifter = `SPMSP_ONES;
            end
            st_d.state    = SPMSP_IDLE;
            st_d.bit_cnt  = 3'h0;
            st_d.edge_odd = 1'b1;
            st_d.out_bit  = head_bit(st_d.shifter, low_bit_first);
         end else if (sck_edge) begin
            // only an idle port arms; a byte in done waits for its last edge
            if (st_q.state == SPMSP_IDLE) begin
               st_d.state = SPMSP_SHIFT;
            end
            st_d.edge_odd = ~st_q.edge_odd;
            sample_now    = (st_q.edge_odd ^ cfg_clk_phase);
            if (~sample_now) st_d.out_bit = head_bit(st_q.shifter, low_bit_first);
         end
      end
      // master: divide and toggle the shift clock
      // runs on in done so phase 0 still gets its trailing edge
      if (is_master & (st_q.state != SPMSP_IDLE)) begin
         if (st_q.div_cnt == 8'h01) begin
            st_d.div_cnt  = half_period(rate_select);
            st_d.sclk     = ~st_q.sclk;
            st_d.edge_odd = ~st_q.edge_odd;
            sample_now    = (st_q.edge_odd ^ cfg_clk_phase);
            // drive the next bit on the non-sampling edge
            if (~sample_now) begin
               st_d.out_bit = head_bit(st_q.shifter, low_bit_first);
            end
         end else begin
            st_d.div_cnt = st_q.div_cnt - 8'h01;
         end
      end
      // sample one bit and finish the byte
      if (sample_now) begin
         st_d.shifter = shift_in(st_q.shifter, low_bit_first, in_bit);
         // outgoing bit moves on the other edge, away from the capture
         st_d.bit_cnt = st_q.bit_cnt + 3'h1;
         if (st_q.bit_cnt == `SPMSP_BIT_LAST) begin
            st_d.state = SPMSP_DONE;
         end
      end
      // byte done: hand to read buffer unless still unread
      // wait for the trailing clock edge of the byte; a deselected slave
      // ends at once, and with select held low the next byte may follow
      if (st_q.state == SPMSP_DONE & (st_q.edge_odd | (~st_q.master & ~ss_low))) begin
         st_d.state   = SPMSP_IDLE;
         st_d.done    = 1'b1;
         st_d.bit_cnt = 3'h0;
         if (st_q.buf_full & ~done_clear) begin
            st_d.ovr = 1'b1;
         end else begin
            rx_load       = 1'b1;
            st_d.buf_full = 1'b1;
         end
      end
      // mode fault on a low select input in master role 00
      if (is_master & (role == `SPMSP_ROLE_FAULT) & ss_low) begin
         st_d.fault  = 1'b1;
         st_d.master = 1'b0;
         st_d.enable = 1'b0;
         st_d.state  = SPMSP_IDLE;
      end
      // disabled port does nothing
      if (~st_q.enable) begin
         st_d.state = SPMSP_IDLE;
         st_d.sclk  = 1'b0;
      end
   end

   // register the whole state; select sync starts at its idle high level
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= '{state: SPMSP_IDLE, sck_sync: 3'h0, ss_sync: 2'h3,
                   mosi_sync: 2'h0, miso_sync: 2'h0, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // read buffer
   // ************************************************************
   // the finished byte is taken in the done cycle
   assign rx_byte = st_d.shifter;
   spmsp_rx_buffer u_rx_buffer (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .load      (rx_load),
      .load_data (rx_byte),
      .read_data (serial_data_reg)
   );

   // ************************************************************
   // outputs and pin control
   // ************************************************************
   logic active;
   // flags and status straight from the state
   assign active               = st_q.state != SPMSP_IDLE;
   assign port_enable          = st_q.enable;
   assign master_select        = st_q.master;
   assign transfer_done_flag   = st_q.done;
   assign overrun_flag         = st_q.ovr;
   assign write_collision_flag = st_q.col;
   assign fault_flag           = st_q.fault;
   assign port_irq             = port_irq_enable & (st_q.done | st_q.fault);
   assign port_busy            = active;
   // master drives clock and mosi; slave takes clock as input
   assign shift_clock_line_out = st_q.sclk ^ cfg_clk_polarity;
   assign shift_clock_line_oe  = is_master;
   assign mosi_out             = st_q.out_bit;
   assign mosi_oe              = is_master;
   assign miso_out             = st_q.out_bit;
   assign miso_oe              = st_q.enable & ~st_q.master & ss_low;
   // select pin role: master only; slave always input
   always_comb begin
      select_n_out = 1'b1;
      select_n_oe  = 1'b0;
      if (is_master) begin
         if (role == `SPMSP_ROLE_OUTPUT) begin
            select_n_out = ~active;
            select_n_oe  = 1'b1;
         end else if (role == `SPMSP_ROLE_GPIO) begin
            select_n_out = gpio_select_out;
            select_n_oe  = 1'b1;
         end
      end
   end
endmodule : spmsp_port

// File: verilog/spmsp_defs.svh
`ifndef SPMSP_DEFS_SVH
`define SPMSP_DEFS_SVH
// ************************************************************
// rate divider half periods (cpu clocks per shift clock half)
// ************************************************************
`define SPMSP_HALF_DIV8    8'h04
`define SPMSP_HALF_DIV32   8'h10
`define SPMSP_HALF_DIV128  8'h40
`define SPMSP_HALF_DIV256  8'h80
// ************************************************************
// byte geometry and codes
// ************************************************************
`define SPMSP_BIT_LAST     3'h7
`define SPMSP_ONES         8'hFF
`define SPMSP_ZERO8        8'h00
`define SPMSP_RATE_DIV8    2'h0
`define SPMSP_RATE_DIV32   2'h1
`define SPMSP_RATE_DIV128  2'h2
`define SPMSP_ROLE_FAULT   2'h0
`define SPMSP_ROLE_GPIO    2'h2
`define SPMSP_ROLE_OUTPUT  2'h3
`endif

// File: verilog/spmsp_pkg.sv
package spmsp_pkg;
   // transfer state, one-hot
   typedef enum logic [2:0] {
      SPMSP_IDLE  = 3'b001,
      SPMSP_SHIFT = 3'b010,
      SPMSP_DONE  = 3'b100
   } spmsp_state_t;
endpackage : spmsp_pkg

// File: verilog/spmsp_rx_buffer.sv
`timescale 1ns/10ps
`include "spmsp_defs.svh"
// ************************************************************
// receive read buffer: holds one byte, registered read data
// ************************************************************
module spmsp_rx_buffer (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       load,
   input  wire logic [7:0] load_data,
   output logic      [7:0] read_data
);
   typedef struct packed {
      logic [7:0] data;
   } spmsp_rxb_t;

   spmsp_rxb_t st_q;
   spmsp_rxb_t st_d;

   // capture a completed byte
   always_comb begin
      st_d = st_q;
      if (load) begin
         st_d.data = load_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= '{data: `SPMSP_ZERO8};
      end else begin
         st_q <= st_d;
      end
   end

   assign read_data = st_q.data;
endmodule : spmsp_rx_buffer

// File: tb/spmsp_port_chk.sv
`timescale 1ns/10ps
// ********
// port checker
// ********
module spmsp_port_chk (
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic [1:0] rate_select,
   input wire logic       select_pin_override,
   input wire logic       select_output_enable,
   input wire logic       data_wr,
   input wire logic [7:0] serial_data_reg,
   input wire logic       done_clear,
   input wire logic       port_enable,
   input wire logic       master_select,
   input wire logic       transfer_done_flag,
   input wire logic       overrun_flag,
   input wire logic       write_collision_flag,
   input wire logic       fault_flag,
   input wire logic       port_busy,
   input wire logic       shift_clock_line_out,
   input wire logic       shift_clock_line_oe,
   input wire logic       select_n_in,
   input wire logic       select_n_out,
   input wire logic       select_n_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic       sclk_q, seen_q, chg, role_out, role_flt;
   logic [8:0] gap_q, half;
   // cpu clocks between shift clock toggles
   assign chg = shift_clock_line_out != sclk_q;
   assign half = (rate_select == 2'h0) ? 9'h004 : (rate_select == 2'h1) ? 9'h010 :
                 (rate_select == 2'h2) ? 9'h040 : 9'h080;
   assign role_out = master_select && port_enable && select_pin_override && select_output_enable;
   assign role_flt = master_select && port_enable && !select_pin_override && !select_output_enable;
   always_ff @(posedge clk_sys) begin
      sclk_q <= shift_clock_line_out;
      gap_q  <= chg ? 9'h000 : gap_q + 9'h001;
      seen_q <= port_busy && (seen_q || chg);
   end
   sequence s_sel_idle; role_out && !port_busy; endsequence
   sequence s_end; port_busy && master_select ##1 !port_busy; endsequence
   property p_rate; chg && seen_q && port_busy && master_select |-> gap_q == half - 9'h001;
   endproperty
   property p_sel_idle; s_sel_idle ##1 s_sel_idle |-> select_n_out && select_n_oe; endproperty
   property p_slave_in; !master_select ##1 !master_select |-> !select_n_oe && !shift_clock_line_oe;
   endproperty
   property p_off; !port_enable ##1 !port_enable |-> !port_busy && !shift_clock_line_oe;
   endproperty
   property p_coll; port_busy && data_wr && port_enable |=> write_collision_flag; endproperty
   property p_done; $fell(port_busy) && master_select && !fault_flag |-> transfer_done_flag;
   endproperty
   property p_fault; role_flt && !select_n_in |-> ##[1:4] (fault_flag && !port_enable);
   endproperty
   property p_overrun; (transfer_done_flag && !done_clear) ##0 s_end |->
      overrun_flag && $stable(serial_data_reg); endproperty
   property p_buf; !$past(srst) && $changed(serial_data_reg) |-> transfer_done_flag; endproperty
   a_rate: assert property (p_rate) else $error("shift clock half period wrong");
   a_sel_idle: assert property (p_sel_idle) else $error("select not high when idle");
   a_slave_in: assert property (p_slave_in) else $error("slave drives clock or select");
   a_off: assert property (p_off) else $error("disabled port active");
   a_coll: assert property (p_coll) else $error("collision flag missing");
   a_done: assert property (p_done) else $error("done flag missing");
   a_fault: assert property (p_fault) else $error("mode fault missing");
   a_overrun: assert property (p_overrun) else $error("overrun handling wrong");
   a_buf: assert property (p_buf) else $error("read buffer changed early");
endmodule : spmsp_port_chk
bind spmsp_port spmsp_port_chk chk_u (.clk_sys(clk_sys), .srst(srst),
   .rate_select(rate_select), .select_pin_override(select_pin_override),
   .select_output_enable(select_output_enable), .data_wr(data_wr),
   .serial_data_reg(serial_data_reg), .done_clear(done_clear), .port_enable(port_enable),
   .master_select(master_select), .transfer_done_flag(transfer_done_flag),
   .overrun_flag(overrun_flag), .write_collision_flag(write_collision_flag),
   .fault_flag(fault_flag), .port_busy(port_busy), .shift_clock_line_out(shift_clock_line_out),
   .shift_clock_line_oe(shift_clock_line_oe), .select_n_in(select_n_in),
   .select_n_out(select_n_out), .select_n_oe(select_n_oe));

// File: tb/spmsp_slave_model.sv
`timescale 1ns/10ps
// ********
// external slave device
// ********
module spmsp_slave_model (
   input  wire logic       sclk,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       lsb,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic      [7:0] rx
);
   logic [7:0] sh;
   logic [3:0] idx;
   logic       bitv, last;
   initial begin
      rx = 8'h00; sh = 8'h00; idx = 4'h0; last = 1'b0;
   end
   // load reply byte on select
   always @(negedge ss_n) begin
      sh = tx;
      idx = cpha ? 4'hF : 4'h0;
   end
   // sample on first edge for phase 0, second for phase 1
   always @(sclk) begin
      if (!ss_n && ((sclk != cpol) != cpha)) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      else if (!ss_n) idx = idx + 4'h1;
   end
   // released line shows inverse of last bit
   assign bitv = sh[lsb ? idx[2:0] : 3'h7 - idx[2:0]];
   always @(*) if (!ss_n) last = bitv;
   assign miso = ss_n ? ~last : bitv;
endmodule : spmsp_slave_model

// File: tb/tb_spi_master_slave_port.sv
`timescale 1ns/10ps
// ********
// port testbench
// ********
module tb_spi_master_slave_port;
   logic clk_sys = 1'b0, srst = 1'b1, en_set = 1'b0, ms_set = 1'b0, cpol = 1'b0, cpha = 1'b0;
   logic lsb = 1'b0, ovr = 1'b1, soe = 1'b1, irq_en = 1'b0, data_wr = 1'b0, done_clr = 1'b0;
   logic ovr_clr = 1'b0, col_clr = 1'b0, flt_clr = 1'b0, b_sclk = 1'b0, b_ss_n = 1'b1;
   logic b_mosi = 1'b1, done_q = 1'b0;
   logic [1:0] rate = 2'h1;
   logic [7:0] wr_val = 8'h00, m_tx = 8'h00, rd, m_rx, v, t;
   logic [16:0] note;
   logic [16:0] expq[$];
   logic p_en, m_sel, done_f, ovr_f, col_f, flt_f, irq, busy, sclk_o, sclk_oe, ss_o, ss_oe;
   logic mosi_o, mosi_oe, miso_o, miso_oe, m_miso, sclk_w, ss_w, mosi_w, miso_w;
   int bad_count = 0, check_count = 0, cyc = 0, seed = 7;
   // pin levels; select line pulled high
   assign sclk_w = sclk_oe ? sclk_o : b_sclk;
   assign ss_w = ss_oe ? ss_o : b_ss_n;
   assign mosi_w = mosi_oe ? mosi_o : b_mosi;
   assign miso_w = miso_oe ? miso_o : m_miso;
   spmsp_port dut_u (.clk_sys(clk_sys), .srst(srst), .port_enable_set(en_set),
      .master_select_set(ms_set), .cfg_clk_polarity(cpol), .cfg_clk_phase(cpha),
      .low_bit_first(lsb), .rate_select(rate), .select_pin_override(ovr),
      .select_output_enable(soe), .port_irq_enable(irq_en), .gpio_select_out(1'b1),
      .data_wr(data_wr), .data_wr_value(wr_val), .serial_data_reg(rd), .done_clear(done_clr),
      .overrun_clear(ovr_clr), .collision_clear(col_clr), .fault_clear(flt_clr),
      .port_enable(p_en), .master_select(m_sel), .transfer_done_flag(done_f),
      .overrun_flag(ovr_f), .write_collision_flag(col_f), .fault_flag(flt_f), .port_irq(irq),
      .port_busy(busy), .shift_clock_line_in(sclk_w), .shift_clock_line_out(sclk_o),
      .shift_clock_line_oe(sclk_oe), .select_n_in(ss_w), .select_n_out(ss_o),
      .select_n_oe(ss_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_oe),
      .miso_in(miso_w), .miso_out(miso_o), .miso_oe(miso_oe));
   spmsp_slave_model mdl_u (.sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .cpol(cpol),
      .cpha(cpha), .lsb(lsb), .tx(m_tx), .miso(m_miso), .rx(m_rx));
   initial forever #20 clk_sys = ~clk_sys;
   task automatic results;
      if (bad_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] d);
      @(negedge clk_sys);
      data_wr = 1'b1;
      wr_val = d;
      @(negedge clk_sys);
      data_wr = 1'b0;
   endtask : wr
   task automatic idle_clr(input logic clr = 1'b1);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      chk("busy", 8'h00, {7'h00, busy});
      @(negedge clk_sys);
      {done_clr, ovr_clr, col_clr} = {3{clr}};
      @(negedge clk_sys);
      {done_clr, ovr_clr, col_clr} = 3'h0;
   endtask : idle_clr
   // cycle ceiling
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         results();
      end
   end
   // compare each byte that raises the done flag with the oldest note
   always @(negedge clk_sys) begin
      done_q <= done_f;
      if (done_f === 1'b1 && done_q === 1'b0) begin
         if (expq.size() == 0) chk("stray done", 8'h00, 8'h01);
         else begin
            note = expq.pop_front();
            chk("read buffer", note[15:8], rd);
            if (note[16]) chk("slave rx", note[7:0], m_rx);
         end
      end
   end
   // main sequence
   initial begin
      repeat (20) @(negedge clk_sys);
      srst = 1'b0;
      en_set = 1'b1;
      ms_set = 1'b1;
      for (int i = 0; i < 16; i++) begin
         v = 8'($random(seed));
         t = 8'($random(seed));
         {cpol, cpha, rate, lsb, m_tx} = {i[3:0], v[0], t};
         repeat (3) @(negedge clk_sys);
         expq.push_back({1'b1, t, v});
         wr(v);
         if (i == 5) wr(~v);
         if (i == 5) chk("collision", 8'h01, {7'h00, col_f});
         idle_clr();
      end
      expq.push_back({1'b1, t, v});
      wr(v);
      idle_clr(1'b0);
      wr(8'h3C);
      idle_clr(1'b0);
      wr(8'hC3);
      idle_clr(1'b0);
      chk("overrun", 8'h01, {7'h00, ovr_f});
      chk("kept byte", t, rd);
      chk("second rx", 8'hC3, m_rx);
      idle_clr();
      en_set = 1'b0;
      repeat (3) @(negedge clk_sys);
      wr(8'hA5);
      chk("disabled", 8'h00, {7'h00, busy});
      {en_set, ovr, soe, irq_en, b_ss_n} = 5'h12;
      repeat (8) @(negedge clk_sys);
      chk("fault", 8'h03, {6'h00, flt_f, irq});
      {ms_set, en_set, b_ss_n, flt_clr} = 4'h3;
      @(negedge clk_sys);
      {en_set, flt_clr, cpol, cpha, lsb} = 5'h10;
      repeat (3) @(negedge clk_sys);
      chk("slave mode", 8'h00, {7'h00, m_sel});
      wr(8'h96);
      expq.push_back({1'b0, 8'h5A, 8'h00});
      b_ss_n = 1'b0;
      for (int k = 7; k >= 0; k--) begin
         b_mosi = 1'((8'h5A >> k) & 8'h01);
         repeat (8) @(negedge clk_sys);
         b_sclk = 1'b1;
         chk("miso", (8'h96 >> k) & 8'h01, {7'h00, miso_w});
         repeat (8) @(negedge clk_sys);
         b_sclk = 1'b0;
      end
      repeat (8) @(negedge clk_sys);
      b_ss_n = 1'b1;
      idle_clr();
      b_ss_n = 1'b0;
      repeat (3) begin
         repeat (8) @(negedge clk_sys);
         b_sclk = ~b_sclk;
      end
      b_ss_n = 1'b1;
      idle_clr();
      chk("abort kept", 8'h5A, rd);
      chk("notes left", 8'h00, 8'(expq.size()));
      results();
   end
endmodule : tb_spi_master_slave_port
